// *** rtl/sabt_top.sv ***
// Serial bus arbiter and bit timer with register port and interrupt.
//
// Overview of operation
// - Done flag sets when a measurement ends; control write or reset clears.
// - Running flag reads one while counting, zero when stopped.
// - Overflow flag sets on counter overflow; control write or reset clears.
// - Nine-bit read-only counter, top bit in control; write clears.
// - Mode zero keeps the counter cleared and idle.
// - Clock select zero: bus clock by four, falling edge to falling edge.
// - Clock select zero: running while counting, done on second fall.
// - Clock select one: half prescaler rate, low level to rising edge.
// - Clock select one with receive already low starts at once.
// - Mode two arbitrates, restarting on each transmit rising edge.
// - Receive sampled once at 38h or 08h; low sets lost.
// - Lost flag forces the transmit pin high.
// - Transmit falling with no receive low seen resets the counter.
// - Mode field: idle, measure, arbitrate, reserved; reset clears it.
// - Writing zero to mode high bit clears lost flag.
`include "sabt_cfg.svh"
`default_nettype none
module sabt_top (
   input  wire logic                   sys_clk,
   input  wire logic                   arst_n,
   input  wire logic                   clk_en,
   input  wire sabt_pkg::sabt_bus_req_t bus_req,
   output var  logic [7:0]             rdata,
   input  wire logic                   rx_pin,
   input  wire logic                   internal_transmit_signal,
   input  wire logic                   presc_tick,
   output var  logic                   tx_pin,
   output var  logic                   irq
);
   import sabt_pkg::*;

   // ==========================================================
   // Constants and helpers
   // ==========================================================

   localparam int SW = $bits(sabt_state_t);
   localparam sabt_state_t STATE_RST =
      sabt_state_t'({{(SW - 1){1'b0}}, `SABT_TX_RST});

   function automatic logic hit(input logic [3:0] a,
                                input logic [3:0] off);
      hit = (a == off);
   endfunction

   // Returns the incremented count with the carry out on top.
   function automatic logic [9:0] step(input logic [8:0] c);
      step = {1'b0, c} + 10'h001;
   endfunction

   function automatic logic [7:0] ctrl_word(input sabt_state_t st);
      logic [7:0] w;
      w = 8'h00;
      w[`SABT_B_MODE_LO] = st.mode[0];
      w[`SABT_B_MODE_HI] = st.mode[1];
      w[`SABT_B_LOST]    = st.lost;
      w[`SABT_B_CLKSEL]  = st.clk_sel;
      w[`SABT_B_TOP]     = st.cnt[8];
      w[`SABT_B_OVF]     = st.ovf;
      w[`SABT_B_RUN]     = (st.fsm == ST_RUN);
      w[`SABT_B_DONE]    = st.done;
      ctrl_word = w;
   endfunction

   // ==========================================================
   // Receive synchroniser
   // ==========================================================

   logic rx_s;

   sabt_sync u_rx_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .async_in (rx_pin),
      .sync_out (rx_s)
   );

   // ==========================================================
   // Next state
   // ==========================================================

   sabt_state_t s_reg;
   sabt_state_t s_next;
   logic        rx_fall;
   logic        rx_rise;
   logic        tx_rise;
   logic        tx_fall;
   logic        tick;
   logic        wr_ctrl;
   logic        ev_done;
   logic        ev_ovf;
   logic        ev_lost;
   logic [8:0]  thr;
   logic [9:0]  inc;

   always_comb begin
      s_next  = s_reg;
      rx_fall = s_reg.rx_prev & ~rx_s;
      rx_rise = ~s_reg.rx_prev & rx_s;
      tx_rise = ~s_reg.tx_prev & internal_transmit_signal;
      tx_fall = s_reg.tx_prev & ~internal_transmit_signal;
      wr_ctrl = bus_req.wr & hit(bus_req.addr, `SABT_ADDR_CTRL);
      ev_done = 1'b0;
      ev_ovf  = 1'b0;
      ev_lost = 1'b0;
      inc     = step(s_reg.cnt);
      thr     = s_reg.clk_sel ? `SABT_THR_PRESC : `SABT_THR_DIV4;

      s_next.rx_prev = rx_s;
      s_next.tx_prev = internal_transmit_signal;

      // Counter time base: bus clock by four, or half the prescaler.
      s_next.pre = s_reg.pre + 2'h1;
      if (presc_tick) begin
         s_next.half = ~s_reg.half;
      end
      tick = s_reg.clk_sel ? (presc_tick & s_reg.half)
                           : (s_reg.pre == `SABT_DIV4_LAST);

      case (s_reg.mode)
         `SABT_MODE_MEAS: begin
            case (s_reg.fsm)
               ST_IDLE, ST_WAIT: begin
                  // Clock select one starts on a low level, so a line
                  // already low at enable starts the count at once.
                  if (s_reg.clk_sel ? ~rx_s : rx_fall) begin
                     s_next.fsm = ST_RUN;
                     s_next.cnt = 9'h000;
                  end
               end
               ST_RUN: begin
                  if (s_reg.clk_sel ? rx_rise : rx_fall) begin
                     s_next.fsm = ST_DONE;
                     ev_done    = 1'b1;
                  end else if (tick) begin
                     s_next.cnt = inc[8:0];
                     ev_ovf     = inc[9];
                  end
               end
               default: begin
               end
            endcase
         end
         `SABT_MODE_ARB: begin
            if (tx_rise) begin
               s_next.fsm         = ST_RUN;
               s_next.cnt         = 9'h000;
               s_next.sampled     = 1'b0;
               s_next.rx_low_seen = 1'b0;
            end else if (s_reg.fsm == ST_RUN) begin
               if (!rx_s) begin
                  s_next.rx_low_seen = 1'b1;
               end
               if (tx_fall && !(s_reg.rx_low_seen || !rx_s)) begin
                  s_next.fsm = ST_WAIT;
                  s_next.cnt = 9'h000;
               end else begin
                  if (s_reg.cnt == thr && !s_reg.sampled) begin
                     s_next.sampled = 1'b1;
                     ev_lost        = ~rx_s;
                  end
                  if (tick) begin
                     s_next.cnt = inc[8:0];
                     ev_ovf     = inc[9];
                  end
               end
            end
         end
         default: begin
            // Idle and the reserved code hold the counter cleared.
            s_next.fsm = ST_IDLE;
            s_next.cnt = 9'h000;
         end
      endcase

      // A control write restarts the unit and clears its counter.
      if (wr_ctrl) begin
         s_next.mode[0] = bus_req.wdata[`SABT_B_MODE_LO];
         s_next.mode[1] = bus_req.wdata[`SABT_B_MODE_HI];
         s_next.clk_sel = bus_req.wdata[`SABT_B_CLKSEL];
         s_next.cnt     = 9'h000;
         s_next.fsm     = ST_IDLE;
         s_next.sampled = 1'b0;
      end

      // Flags: a hardware set wins over a clear in the same cycle.
      s_next.done = (s_reg.done & ~wr_ctrl) | ev_done;
      s_next.ovf  = (s_reg.ovf & ~wr_ctrl) | ev_ovf;
      s_next.lost = (s_reg.lost
                     & ~(wr_ctrl & ~bus_req.wdata[`SABT_B_MODE_HI]))
                    | ev_lost;

      // Interrupt status is write-one-to-clear.
      if (bus_req.wr && hit(bus_req.addr, `SABT_ADDR_IMASK)) begin
         s_next.imask = bus_req.wdata[2:0];
      end
      if (bus_req.wr && hit(bus_req.addr, `SABT_ADDR_ISTAT)) begin
         s_next.ist = s_reg.ist & ~bus_req.wdata[2:0];
      end
      s_next.ist[`SABT_I_DONE] = s_next.ist[`SABT_I_DONE] | ev_done;
      s_next.ist[`SABT_I_OVF]  = s_next.ist[`SABT_I_OVF] | ev_ovf;
      s_next.ist[`SABT_I_LOST] = s_next.ist[`SABT_I_LOST] | ev_lost;
      s_next.irq = |(s_next.ist & s_next.imask);

      // Read data stands only in the cycle after the strobe.
      s_next.rdata = 8'h00;
      if (bus_req.rd) begin
         if (hit(bus_req.addr, `SABT_ADDR_CTRL)) begin
            s_next.rdata = ctrl_word(s_reg);
         end else if (hit(bus_req.addr, `SABT_ADDR_COUNT)) begin
            s_next.rdata = s_reg.cnt[7:0];
         end else if (hit(bus_req.addr, `SABT_ADDR_ISTAT)) begin
            s_next.rdata = {5'h00, s_reg.ist};
         end else if (hit(bus_req.addr, `SABT_ADDR_IMASK)) begin
            s_next.rdata = {5'h00, s_reg.imask};
         end
      end

      // A lost arbitration holds the line recessive.
      s_next.tx_pin = s_next.lost | internal_transmit_signal;
   end

   // ==========================================================
   // State register
   // ==========================================================

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg         <= STATE_RST;
         // Edge detectors start at the idle level of their lines.
         s_reg.rx_prev <= `SABT_RX_RST;
         s_reg.tx_prev <= `SABT_TX_RST;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign rdata  = s_reg.rdata;
   assign tx_pin = s_reg.tx_pin;
   assign irq    = s_reg.irq;

   // ==========================================================
   // Assertions
   // ==========================================================

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   property p_wr_clears_count;
      clk_en && wr_ctrl && !ev_ovf |=> s_reg.cnt == 9'h000 && !s_reg.ovf;
   endproperty
   a_wr_clears_count: assert property (p_wr_clears_count)
      else $error("Control write did not clear counter and overflow.");

   property p_idle_holds;
      s_reg.mode == `SABT_MODE_IDLE |->
         s_reg.cnt == 9'h000 && s_reg.fsm != ST_RUN;
   endproperty
   a_idle_holds: assert property (p_idle_holds)
      else $error("Idle mode left the counter running.");

   property p_lost_forces_tx;
      s_reg.lost |-> tx_pin;
   endproperty
   a_lost_forces_tx: assert property (p_lost_forces_tx)
      else $error("Transmit pin low while arbitration is lost.");

   property p_overflow_sets;
      clk_en && !wr_ctrl && s_reg.fsm == ST_RUN && tick
         && s_reg.cnt == `SABT_CNT_MAX
         && !(s_reg.mode == `SABT_MODE_ARB && tx_rise)
         && !(s_reg.mode == `SABT_MODE_MEAS
              && (s_reg.clk_sel ? rx_rise : rx_fall))
         && !(s_reg.mode == `SABT_MODE_ARB && tx_fall)
      |=> s_reg.ovf && s_reg.cnt == 9'h000;
   endproperty
   a_overflow_sets: assert property (p_overflow_sets)
      else $error("Counter wrap did not set overflow.");

   property p_done_on_fall;
      clk_en && !wr_ctrl && s_reg.mode == `SABT_MODE_MEAS
         && !s_reg.clk_sel && s_reg.fsm == ST_RUN && rx_fall
      |=> s_reg.done && s_reg.fsm != ST_RUN;
   endproperty
   a_done_on_fall: assert property (p_done_on_fall)
      else $error("Second falling edge did not finish measurement.");

   property p_count_read;
      clk_en && bus_req.rd && hit(bus_req.addr, `SABT_ADDR_COUNT)
      |=> rdata == $past(s_reg.cnt[7:0]);
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("Count read returned a stale value.");

   property p_lost_on_low_sample;
      clk_en && s_reg.mode == `SABT_MODE_ARB && s_reg.fsm == ST_RUN
         && !tx_rise && !tx_fall && s_reg.cnt == thr
         && !s_reg.sampled && !rx_s
      |=> s_reg.lost [*2];
   endproperty
   a_lost_on_low_sample: assert property (p_lost_on_low_sample)
      else $error("Low sample did not set arbitration lost.");

   property p_arb_restart;
      clk_en && !wr_ctrl && s_reg.mode == `SABT_MODE_ARB && tx_rise
      |=> s_reg.fsm == ST_RUN && s_reg.cnt == 9'h000;
   endproperty
   a_arb_restart: assert property (p_arb_restart)
      else $error("Transmit rising edge did not restart the counter.");

   property p_tx_fall_reset;
      clk_en && !wr_ctrl && s_reg.mode == `SABT_MODE_ARB
         && s_reg.fsm == ST_RUN && tx_fall && rx_s
         && !s_reg.rx_low_seen
      |=> s_reg.fsm == ST_WAIT && s_reg.cnt == 9'h000;
   endproperty
   a_tx_fall_reset: assert property (p_tx_fall_reset)
      else $error("Unopposed transmit fall did not reset counter.");

   property p_lost_clear;
      clk_en && wr_ctrl && !bus_req.wdata[`SABT_B_MODE_HI]
         && !ev_lost
      |=> !s_reg.lost;
   endproperty
   a_lost_clear: assert property (p_lost_clear)
      else $error("Writing zero to mode high kept lost set.");

   property p_low_start;
      clk_en && !wr_ctrl && s_reg.mode == `SABT_MODE_MEAS
         && s_reg.clk_sel && s_reg.fsm == ST_IDLE && !rx_s
      |=> s_reg.fsm == ST_RUN
          && (ctrl_word(s_reg) & (8'h01 << `SABT_B_RUN)) != 8'h00;
   endproperty
   a_low_start: assert property (p_low_start)
      else $error("Low receive level did not start measurement.");

   c_done: cover property (s_reg.done && !$past(s_reg.done));
   c_lost: cover property (s_reg.lost && !$past(s_reg.lost));
   c_ovf: cover property (s_reg.ovf && !$past(s_reg.ovf));
   c_irq: cover property (irq);

endmodule // sabt_top
`default_nettype wire

// *** rtl/sabt_cfg.svh ***
// Offsets, field positions, reset values and counts of the arbiter timer.
`ifndef SABT_CFG_SVH
`define SABT_CFG_SVH

// Register offsets on the plain register port.
`define SABT_ADDR_CTRL   4'h0
`define SABT_ADDR_COUNT  4'h1
`define SABT_ADDR_ISTAT  4'h2
`define SABT_ADDR_IMASK  4'h3

// Field positions in the control and status register.
`define SABT_B_MODE_LO   0
`define SABT_B_MODE_HI   1
`define SABT_B_LOST      2
`define SABT_B_CLKSEL    3
`define SABT_B_TOP       4
`define SABT_B_OVF       5
`define SABT_B_RUN       6
`define SABT_B_DONE      7

// Interrupt status and mask bit positions.
`define SABT_I_DONE      0
`define SABT_I_OVF       1
`define SABT_I_LOST      2

// Mode select encodings.
`define SABT_MODE_IDLE   2'h0
`define SABT_MODE_MEAS   2'h1
`define SABT_MODE_ARB    2'h2

// Arbitration sample points and counter figures.
`define SABT_THR_DIV4    9'h038
`define SABT_THR_PRESC   9'h008
`define SABT_DIV4_LAST   2'h3
`define SABT_CNT_MAX     9'h1ff

// Reset levels of the serial lines.
`define SABT_RX_RST      1'b1
`define SABT_TX_RST      1'b1

`endif

// *** rtl/sabt_pkg.sv ***
// Types shared by the arbiter timer design files.
`default_nettype none
package sabt_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_RUN,
      ST_DONE
   } sabt_fsm_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sabt_bus_req_t;

   typedef struct packed {
      sabt_fsm_t  fsm;
      logic [8:0] cnt;
      logic       ovf;
      logic       done;
      logic       lost;
      logic       clk_sel;
      logic [1:0] mode;
      logic [1:0] pre;
      logic       half;
      logic       rx_prev;
      logic       tx_prev;
      logic       rx_low_seen;
      logic       sampled;
      logic [2:0] ist;
      logic [2:0] imask;
      logic [7:0] rdata;
      logic       irq;
      logic       tx_pin;
   } sabt_state_t;

endpackage
`default_nettype wire

// *** rtl/sabt_sync.sv ***
// Three-stage synchroniser that passes a level once two stages agree.
`include "sabt_cfg.svh"
`default_nettype none
module sabt_sync (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic clk_en,
   input  wire logic async_in,
   output var  logic sync_out
);

   logic [2:0] stage_reg;
   logic       out_reg;

   // The first stage feeds only the second; the output follows agreement.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage_reg <= {3{`SABT_RX_RST}};
         out_reg   <= `SABT_RX_RST;
      end else if (clk_en) begin
         stage_reg <= {stage_reg[1:0], async_in};
         if (stage_reg[1] == stage_reg[2]) begin
            out_reg <= stage_reg[2];
         end
      end
   end

   assign sync_out = out_reg;

endmodule // sabt_sync
`default_nettype wire

// *** dv/sabt_bus_node.sv ***
// Model of the other nodes that share the serial bus line.
`default_nettype none
module sabt_bus_node (
   input  wire logic tx_pin,
   input  wire logic pull_low,
   output var  logic rx_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // The line is wired-and with a pull-up, so a node driving low dominates.
   assign rx_line = tx_pin & ~pull_low;
endmodule // sabt_bus_node
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench of the serial arbiter and bit timer.
`include "sabt_cfg.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sabt_pkg::*;

   logic          sys_clk    = 1'b0;
   logic          arst_n     = 1'b0;
   logic          clk_en     = 1'b1;
   sabt_bus_req_t bus_req    = '0;
   logic [7:0]    rdata;
   logic          rx_pin;
   logic          itx        = 1'b1;
   logic          presc_tick = 1'b0;
   logic          tx_pin;
   logic          irq;
   logic          pull_low   = 1'b0;
   int            pdiv       = 3;
   int            pcnt       = 0;
   int            num_errors = 0;
   int            n_checks   = 0;

   always #2.5 sys_clk = ~sys_clk;

   // One prescaler tick every pdiv clock cycles.
   always @(posedge sys_clk) begin
      pcnt <= (pcnt + 1 >= pdiv) ? 0 : pcnt + 1;
      presc_tick <= (pcnt == 0);
   end

   sabt_bus_node node (
      .tx_pin   (tx_pin),
      .pull_low (pull_low),
      .rx_line  (rx_pin)
   );

   sabt_top dut (
      .sys_clk                  (sys_clk),
      .arst_n                   (arst_n),
      .clk_en                   (clk_en),
      .bus_req                  (bus_req),
      .rdata                    (rdata),
      .rx_pin                   (rx_pin),
      .internal_transmit_signal (itx),
      .presc_tick               (presc_tick),
      .tx_pin                   (tx_pin),
      .irq                      (irq)
   );

   // ==========================================================
   // Bus tasks, compares and expectations
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      // Read data stands in the cycle after the strobe; take it mid-cycle.
      @(negedge sys_clk);
      d = rdata;
      @(posedge sys_clk);
   endtask

   task automatic rdcnt(output logic [8:0] v);
      logic [7:0] c;
      logic [7:0] l;
      rd(`SABT_ADDR_CTRL, c);
      rd(`SABT_ADDR_COUNT, l);
      v = {c[`SABT_B_TOP], l};
   endtask

   task automatic chk(input string nm, input logic [8:0] e,
                      input logic [8:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input logic [8:0] g);
      n_checks++;
      if ($isunknown(g) || g < lo || g > hi) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                  nm, lo, hi, g);
      end
   endtask

   // Clock cycles per counter step for a clock select value.
   function automatic int meas_per(input logic cs);
      return cs ? 2 * pdiv : 4;
   endfunction

   // Clock cycles from a transmit rise to the arbitration sample.
   function automatic int arb_cycles(input logic cs);
      return (cs ? int'(`SABT_THR_PRESC) : int'(`SABT_THR_DIV4))
             * meas_per(cs);
   endfunction

   task automatic arb(input logic cs, input logic pull);
      int         t;
      logic [7:0] c;
      logic [8:0] v;
      t = arb_cycles(cs);
      wr(`SABT_ADDR_CTRL, {4'h0, cs, 3'b010});
      itx <= 1'b0;
      repeat (10) @(posedge sys_clk);
      itx <= 1'b1;
      repeat (t / 2) @(posedge sys_clk);
      itx <= 1'b0;
      repeat (5) @(posedge sys_clk);
      itx <= 1'b1;
      repeat (t - 20) @(posedge sys_clk);
      pull_low <= pull;
      repeat (40) @(posedge sys_clk);
      pull_low <= 1'b0;
      rd(`SABT_ADDR_CTRL, c);
      chk_bit("lost", pull, c[`SABT_B_LOST]);
      itx <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_bit("tx forced", pull, tx_pin);
      itx <= 1'b1;
      if (pull) begin
         wr(`SABT_ADDR_CTRL, {4'h0, cs, 3'b010});
         rd(`SABT_ADDR_CTRL, c);
         chk_bit("lost kept", 1'b1, c[`SABT_B_LOST]);
         // With the pin held recessive no echo reaches the receive line.
         itx <= 1'b0;
         repeat (4) @(posedge sys_clk);
         itx <= 1'b1;
         repeat (t / 2) @(posedge sys_clk);
         itx <= 1'b0;
         rd(`SABT_ADDR_CTRL, c);
         chk_bit("stopped on tx fall", 1'b0, c[`SABT_B_RUN]);
         rdcnt(v);
         chk("count on tx fall", 9'h000, v);
         itx <= 1'b1;
         wr(`SABT_ADDR_CTRL, 8'h00);
         rd(`SABT_ADDR_CTRL, c);
         chk_bit("lost cleared", 1'b0, c[`SABT_B_LOST]);
      end
      $display("test arbitration cs=%b pull=%b done", cs, pull);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      logic [7:0] c;
      logic [8:0] v;
      int         n;
      int         h;
      void'($urandom(32'hf37f));
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(`SABT_ADDR_CTRL, c);
      chk("ctrl reset", 9'h000, {1'b0, c});
      rdcnt(v);
      chk("count reset", 9'h000, v);
      chk_bit("tx reset", 1'b1, tx_pin);
      rd(4'hf, c);
      chk("unmapped read", 9'h000, {1'b0, c});
      wr(4'h9, 8'h02);
      clk_en <= 1'b0;
      wr(`SABT_ADDR_CTRL, 8'h02);
      clk_en <= 1'b1;
      rd(`SABT_ADDR_CTRL, c);
      chk("ignored writes", 9'h000, {1'b0, c});
      $display("test reset and bus done");

      for (int m = 0; m < 4; m += 3) begin
         wr(`SABT_ADDR_CTRL, 8'(m));
         pull_low <= 1'b1;
         repeat (40) @(posedge sys_clk);
         pull_low <= 1'b0;
         repeat (40) @(posedge sys_clk);
         rdcnt(v);
         chk("idle count", 9'h000, v);
      end
      $display("test idle modes done");

      wr(`SABT_ADDR_IMASK, 8'h07);
      for (int i = 0; i < 3; i++) begin
         n = 10 + $urandom_range(60);
         h = n * meas_per(1'b0) / 2;
         wr(`SABT_ADDR_CTRL, 8'h01);
         repeat (8) @(posedge sys_clk);
         pull_low <= 1'b1;
         repeat (h) @(posedge sys_clk);
         pull_low <= 1'b0;
         rd(`SABT_ADDR_CTRL, c);
         chk_bit("running", 1'b1, c[`SABT_B_RUN]);
         repeat (h - 2) @(posedge sys_clk);
         pull_low <= 1'b1;
         repeat (10) @(posedge sys_clk);
         pull_low <= 1'b0;
         repeat (10) @(posedge sys_clk);
         rd(`SABT_ADDR_CTRL, c);
         chk_bit("done", 1'b1, c[`SABT_B_DONE]);
         chk_bit("stopped", 1'b0, c[`SABT_B_RUN]);
         rdcnt(v);
         chk_rng("count div4", n - 1, n + 1, v);
      end
      chk_bit("irq done", 1'b1, irq);
      wr(`SABT_ADDR_IMASK, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk_bit("irq masked", 1'b0, irq);
      wr(`SABT_ADDR_IMASK, 8'h07);
      wr(`SABT_ADDR_ISTAT, 8'h07);
      rd(`SABT_ADDR_ISTAT, c);
      chk("istat cleared", 9'h000, {1'b0, c});
      chk_bit("irq cleared", 1'b0, irq);
      wr(`SABT_ADDR_CTRL, 8'h01);
      rd(`SABT_ADDR_CTRL, c);
      chk("ctrl write clears", 9'h001, {1'b0, c});
      $display("test measurement div4 done");

      n = 10 + $urandom_range(40);
      pull_low <= 1'b1;
      repeat (8) @(posedge sys_clk);
      wr(`SABT_ADDR_CTRL, 8'h09);
      rd(`SABT_ADDR_CTRL, c);
      chk_bit("running at once", 1'b1, c[`SABT_B_RUN]);
      repeat (n * meas_per(1'b1) - 2) @(posedge sys_clk);
      pull_low <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rd(`SABT_ADDR_CTRL, c);
      chk_bit("done presc", 1'b1, c[`SABT_B_DONE]);
      rdcnt(v);
      chk_rng("count presc", n - 1, n + 2, v);
      $display("test measurement prescaler done");

      pdiv <= 1;
      pull_low <= 1'b1;
      repeat (8) @(posedge sys_clk);
      wr(`SABT_ADDR_CTRL, 8'h09);
      repeat (1100) @(posedge sys_clk);
      pull_low <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rd(`SABT_ADDR_CTRL, c);
      chk_bit("overflow", 1'b1, c[`SABT_B_OVF]);
      rdcnt(v);
      chk_rng("wrapped count", 36, 42, v);
      wr(`SABT_ADDR_CTRL, 8'h00);
      rd(`SABT_ADDR_CTRL, c);
      chk("overflow cleared", 9'h000, {1'b0, c});
      $display("test overflow done");

      pdiv <= 3;
      for (int k = 0; k < 4; k++) begin
         arb(k[1], k[0]);
      end
      finish_test();
   end

   // Cuts a hang short well beyond the expected run of some 3300 cycles.
   initial begin
      #100us;
      num_errors++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
